// ### inc/spcs_pkg.sv
package spcs_pkg;
  // register map: one byte per address on the plain register port
  localparam logic [7:0] CFG_ADDR = 8'hA1;
  localparam logic [7:0] CTRL_ADDR = 8'hA2;
  localparam logic [7:0] DATA_ADDR = 8'hA3;
  // configuration / status field positions
  localparam int BUSY_B = 7;
  localparam int MSTR_B = 6;
  localparam int PHA_B = 5;
  localparam int POL_B = 4;
  localparam int SEL_B = 3;
  localparam int PIN_B = 2;
  localparam int SHE_B = 1;
  localparam int RXE_B = 0;
  // control field positions
  localparam int EN_B = 0;
  localparam int TXE_B = 1;
  localparam int USE_LO = 2;
  localparam int USE_HI = 3;
  // reset values
  localparam logic [1:0] USAGE_RST = 2'h1;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // select pin usage codes
  localparam logic [1:0] USAGE_3W = 2'h0;
  localparam logic [1:0] USAGE_4W = 2'h1;
  // synchronised inputs: select pin, data-in, link busy, byte toggle, edge toggle
  localparam int SYNC_N = 5;
  localparam int SY_SS = 4;
  localparam int SY_MISO = 3;
  localparam int SY_BUSY = 2;
  localparam int SY_DONE = 1;
  localparam int SY_EDGE = 0;
  localparam logic [4:0] SYNC_RST = 5'h10;
  // timing
  localparam int SYS_CLK_MHZ = 50;
  localparam int HALF_BIT_NS = 100;
  localparam int FILT_NS = 60;
  localparam int HALF_CYC = (HALF_BIT_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int FILT_CYC = (FILT_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] HALF_CNT = 4'(HALF_CYC);
  localparam logic [3:0] PER_LAST = 4'(2 * HALF_CYC - 1);
  localparam logic [3:0] PER_SAMP = 4'(2 * HALF_CYC - 2);
  localparam logic [1:0] FILT_LAST = 2'(FILT_CYC - 1);
  localparam logic [2:0] LAST_BIT = 3'h7;
  // master sequencer
  typedef enum logic [2:0] {
    SPCS_IDLE = 3'b001,
    SPCS_SHIFT = 3'b010,
    SPCS_DONE = 3'b100
  } spcs_mst_e;
endpackage : spcs_pkg

// ### core/spcs_core.sv
`timescale 1ns/1ps
// How it works
// - busy reads 1 while a byte is moving, in master and in slave operation.
// - master_select 0 makes the port a slave, 1 makes it master driving the serial clock.
// - clock_phase 0 centres data on the first clock edge of a bit, 1 on the second.
// - clock_polarity 0 parks the serial clock low when idle, 1 parks it high.
// - selected_filtered is 1 while the select pin is low and 0 while it is high.
// - selected_filtered follows a deglitched copy of the select pin.
// - select_pin_raw returns the unfiltered select pin level from the two-stage synchroniser, two system clocks before the read.
// - shift_empty rises in slave mode once the byte is done and nothing waits; master reads 1.
// - shift_empty drops when a byte enters the shift register or the serial clock moves.
// - receive_empty rises in slave mode after the receive buffer is read, falls on new data.
// - receive_empty reads 1 in master operation.
// - as slave, incoming data is sampled in the middle of each bit.
// - as master, incoming data is sampled one system clock before the bit ends.
// - select_pin_usage picks 3-wire, 4-wire input, or select output copying its low bit.
module spcs_core (
  // system
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // serial clock, link clock when slave
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  // master-out data
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  // slave-out data
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  // slave select, active low
  input wire logic slave_select_n_i,
  output logic slave_select_n_o,
  output logic slave_select_n_oe
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////////
  // configuration and control registers
  logic master_select_reg;
  logic clock_phase_reg;
  logic clock_polarity_reg;
  logic port_enable_reg;
  logic [1:0] select_pin_usage_reg;

  wire cfg_wr = wr && hit(addr, spcs_pkg::CFG_ADDR);
  wire ctrl_wr = wr && hit(addr, spcs_pkg::CTRL_ADDR);
  wire data_wr = wr && hit(addr, spcs_pkg::DATA_ADDR);
  wire data_rd = rd && hit(addr, spcs_pkg::DATA_ADDR);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      master_select_reg <= 1'b0;
      clock_phase_reg <= 1'b0;
      clock_polarity_reg <= 1'b0;
    end else if (cfg_wr) begin
      master_select_reg <= wdata[spcs_pkg::MSTR_B];
      clock_phase_reg <= wdata[spcs_pkg::PHA_B];
      clock_polarity_reg <= wdata[spcs_pkg::POL_B];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      port_enable_reg <= 1'b0;
      select_pin_usage_reg <= spcs_pkg::USAGE_RST;
    end else if (ctrl_wr) begin
      port_enable_reg <= wdata[spcs_pkg::EN_B];
      select_pin_usage_reg <= wdata[spcs_pkg::USE_HI:spcs_pkg::USE_LO];
    end
  end

  wire is_master = master_select_reg;
  wire is_slave = port_enable_reg && !master_select_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: slave shift logic clocked by the serial clock itself
  // the sampling edge is rising for modes 0 and 3, falling for 1 and 2
  wire lnk_clk = sck_i ^ (clock_polarity_reg ^ clock_phase_reg);
  wire four_wire = (select_pin_usage_reg == spcs_pkg::USAGE_4W);
  // frame reset clears the bit counter whenever the pin deselects us in 4-wire usage
  wire lnk_rst_n = rstn && is_slave && !(four_wire && slave_select_n_i);

  logic [2:0] l_cnt_reg;
  logic [2:0] l_lead_reg;
  logic [6:0] l_shift_reg;
  logic l_busy_reg;
  logic [7:0] l_rx_reg;
  logic l_done_tgl_reg;
  logic l_edge_tgl_reg;
  always_ff @(posedge lnk_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      l_cnt_reg <= 3'h0;
      l_shift_reg <= 7'h00;
      l_busy_reg <= 1'b0;
    end else begin
      l_cnt_reg <= l_cnt_reg + 3'h1;
      l_shift_reg <= {l_shift_reg[5:0], mosi_i};
      l_busy_reg <= (l_cnt_reg != spcs_pkg::LAST_BIT);
    end
  end
  // system reset only: a frame reset must fake no event, and idle-time edges count for nothing
  always_ff @(posedge lnk_clk or negedge rstn) begin
    if (!rstn) begin
      l_rx_reg <= 8'h00;
      l_done_tgl_reg <= 1'b0;
      l_edge_tgl_reg <= 1'b0;
    end else begin
      if (lnk_rst_n && (l_cnt_reg != spcs_pkg::LAST_BIT)) begin
        l_edge_tgl_reg <= !l_edge_tgl_reg;
      end
      if (l_cnt_reg == spcs_pkg::LAST_BIT) begin
        l_rx_reg <= {l_shift_reg, mosi_i};
        l_done_tgl_reg <= !l_done_tgl_reg;
      end
    end
  end
  // with phase 1 the output bit advances on the leading edge
  always_ff @(negedge lnk_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      l_lead_reg <= 3'h0;
    end else begin
      l_lead_reg <= l_lead_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // synchronisers into the system domain
  wire [spcs_pkg::SYNC_N-1:0] sync_in = {slave_select_n_i, miso_i, l_busy_reg,
    l_done_tgl_reg, l_edge_tgl_reg};
  logic [spcs_pkg::SYNC_N-1:0] sync1_reg;
  logic [spcs_pkg::SYNC_N-1:0] sync2_reg;

  genvar gi;
  generate
    for (gi = 0; gi < spcs_pkg::SYNC_N; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          sync1_reg[gi] <= spcs_pkg::SYNC_RST[gi];
          sync2_reg[gi] <= spcs_pkg::SYNC_RST[gi];
        end else begin
          sync1_reg[gi] <= sync_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic done_s3_reg;
  logic edge_s3_reg;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_s3_reg <= 1'b0;
      edge_s3_reg <= 1'b0;
    end else begin
      done_s3_reg <= sync2_reg[spcs_pkg::SY_DONE];
      edge_s3_reg <= sync2_reg[spcs_pkg::SY_EDGE];
    end
  end

  wire ss_pin = sync2_reg[spcs_pkg::SY_SS];
  wire miso_in = sync2_reg[spcs_pkg::SY_MISO];
  wire slave_busy = sync2_reg[spcs_pkg::SY_BUSY];
  wire byte_done = is_slave && (sync2_reg[spcs_pkg::SY_DONE] != done_s3_reg);
  wire sck_moved = is_slave && (sync2_reg[spcs_pkg::SY_EDGE] != edge_s3_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // select pin deglitch: a new level must hold for the filter time
  logic sel_n_f_reg;
  logic [1:0] filt_cnt_reg;
  wire filt_diff = (ss_pin != sel_n_f_reg);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_n_f_reg <= 1'b1;
      filt_cnt_reg <= 2'h0;
    end else if (!filt_diff) begin
      filt_cnt_reg <= 2'h0;
    end else if (filt_cnt_reg == spcs_pkg::FILT_LAST) begin
      sel_n_f_reg <= ss_pin;
      filt_cnt_reg <= 2'h0;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 2'h1;
    end
  end

  wire selected_filtered = !sel_n_f_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // transmit buffer, slave output word, receive buffer
  spcs_pkg::spcs_mst_e m_state_reg;
  logic [7:0] tx_buf_reg;
  logic tx_full_reg;
  logic [7:0] tx_word_reg;
  logic [7:0] rx_buf_reg;
  logic shift_empty_reg;
  logic receive_empty_reg;
  logic [7:0] m_shift_reg;

  wire m_idle = (m_state_reg == spcs_pkg::SPCS_IDLE);
  wire slave_load = byte_done || (!slave_busy && shift_empty_reg);
  wire tx_load = tx_full_reg && (is_master ? (m_idle && port_enable_reg) :
    (is_slave && slave_load));
  // a full buffer drops the write rather than corrupt a pending byte
  wire tx_write = data_wr && !tx_full_reg;
  wire rx_take = byte_done && receive_empty_reg;
  wire m_done = (m_state_reg == spcs_pkg::SPCS_DONE);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_buf_reg <= 8'h00;
      tx_full_reg <= 1'b0;
      tx_word_reg <= 8'h00;
    end else begin
      if (tx_write) begin
        tx_buf_reg <= wdata;
      end
      tx_full_reg <= tx_write || (tx_full_reg && !tx_load);
      if (tx_load && is_slave) begin
        tx_word_reg <= tx_buf_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_buf_reg <= 8'h00;
    end else if (rx_take) begin
      rx_buf_reg <= l_rx_reg;
    end else if (m_done) begin
      rx_buf_reg <= m_shift_reg;
    end
  end
  // new data wins over a read in the same cycle
  wire receive_empty_next = rx_take ? 1'b0 : (data_rd ? 1'b1 : receive_empty_reg);
  wire shift_empty_next = is_master ? 1'b1 :
    ((tx_load || sck_moved) ? 1'b0 :
    ((byte_done && !tx_full_reg) ? 1'b1 : shift_empty_reg));
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      receive_empty_reg <= 1'b1;
      shift_empty_reg <= 1'b1;
    end else begin
      receive_empty_reg <= receive_empty_next;
      shift_empty_reg <= shift_empty_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // master sequencer: bit period of two half-bit times from the system clock
  logic [3:0] m_cnt_reg;
  logic [2:0] m_bit_reg;
  logic sck_reg;
  logic mosi_reg;

  wire m_shift = (m_state_reg == spcs_pkg::SPCS_SHIFT);
  wire m_end = m_shift && (m_cnt_reg == spcs_pkg::PER_LAST);
  wire m_sample = m_shift && (m_cnt_reg == spcs_pkg::PER_SAMP);
  wire m_late_half = (m_cnt_reg >= spcs_pkg::HALF_CNT);
  wire sck_active = clock_phase_reg ? !m_late_half : m_late_half;
  wire sck_next = clock_polarity_reg ^ (m_shift && sck_active);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      m_state_reg <= spcs_pkg::SPCS_IDLE;
      m_cnt_reg <= 4'h0;
      m_bit_reg <= 3'h0;
      m_shift_reg <= 8'h00;
      mosi_reg <= 1'b0;
    end else begin
      unique case (m_state_reg)
        spcs_pkg::SPCS_IDLE: begin
          if (tx_load && is_master) begin
            m_state_reg <= spcs_pkg::SPCS_SHIFT;
            m_shift_reg <= tx_buf_reg;
            mosi_reg <= tx_buf_reg[7];
            m_cnt_reg <= 4'h0;
            m_bit_reg <= 3'h0;
          end
        end
        spcs_pkg::SPCS_SHIFT: begin
          m_cnt_reg <= m_end ? 4'h0 : m_cnt_reg + 4'h1;
          if (m_sample) begin
            m_shift_reg <= {m_shift_reg[6:0], miso_in};
          end
          if (m_end) begin
            mosi_reg <= m_shift_reg[7];
            m_bit_reg <= m_bit_reg + 3'h1;
            if (m_bit_reg == spcs_pkg::LAST_BIT) begin
              m_state_reg <= spcs_pkg::SPCS_DONE;
            end
          end
        end
        spcs_pkg::SPCS_DONE: begin
          m_state_reg <= spcs_pkg::SPCS_IDLE;
        end
        default: begin
          m_state_reg <= spcs_pkg::SPCS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sck_reg <= 1'b0;
    end else begin
      sck_reg <= sck_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins
  wire [2:0] out_idx = clock_phase_reg ? (l_lead_reg - 3'h1) : l_cnt_reg;
  wire slave_drive = is_slave &&
    ((select_pin_usage_reg == spcs_pkg::USAGE_3W) || selected_filtered);

  assign sck_o = sck_reg;
  assign sck_oe = port_enable_reg && is_master;
  assign mosi_o = mosi_reg;
  assign mosi_oe = port_enable_reg && is_master;
  assign miso_o = tx_word_reg[3'h7 - out_idx];
  assign miso_oe = slave_drive;
  assign slave_select_n_o = select_pin_usage_reg[0];
  assign slave_select_n_oe = select_pin_usage_reg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // read-back
  wire busy_now = is_master ? !m_idle : slave_busy;
  wire shift_empty_rd = is_master || shift_empty_reg;
  wire receive_empty_rd = is_master || receive_empty_reg;
  wire [7:0] cfg_val = {busy_now, master_select_reg, clock_phase_reg, clock_polarity_reg,
    selected_filtered, ss_pin, shift_empty_rd, receive_empty_rd};
  wire [7:0] ctrl_val = {4'h0, select_pin_usage_reg, !tx_full_reg, port_enable_reg};
  wire [7:0] rdata_next = !rd ? spcs_pkg::ZERO_BYTE :
    hit(addr, spcs_pkg::CFG_ADDR) ? cfg_val :
    hit(addr, spcs_pkg::CTRL_ADDR) ? ctrl_val :
    hit(addr, spcs_pkg::DATA_ADDR) ? rx_buf_reg : spcs_pkg::ZERO_BYTE;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_cfg_write;
    cfg_wr ##1 1'b1;
  endsequence
  sequence s_pin_low_held;
    (ss_pin == 1'b0) [*3];
  endsequence

  a_master_shift_empty_one: assert property (is_master && rd && hit(addr, spcs_pkg::CFG_ADDR)
    |=> rdata[spcs_pkg::SHE_B]) else $error("shift_empty not 1 in master");
  a_master_rxe_one: assert property (is_master && rd && hit(addr, spcs_pkg::CFG_ADDR)
    |=> rdata[spcs_pkg::RXE_B]) else $error("receive_empty not 1 in master");
  a_busy_master_run: assert property (is_master && m_shift
    |-> busy_now) else $error("busy low during master byte");
  a_idle_clock_level: assert property (m_idle ##1 m_idle
    |-> sck_o == $past(clock_polarity_reg)) else $error("idle clock level wrong");
  a_select_filter_set: assert property (s_pin_low_held
    |=> selected_filtered) else $error("filtered select not set");
  a_raw_pin_read: assert property (rd && hit(addr, spcs_pkg::CFG_ADDR)
    |=> rdata[spcs_pkg::PIN_B] == $past(ss_pin)) else $error("raw pin read wrong");
  a_cfg_write_store: assert property (s_cfg_write
    |-> {master_select_reg, clock_phase_reg, clock_polarity_reg}
      == $past(wdata[6:4], 1)) else $error("config write not stored");
  a_read_sets_rxe: assert property (data_rd && !rx_take
    |=> receive_empty_reg) else $error("receive_empty not set by read");
  a_load_clears_shift_empty: assert property (tx_load && is_slave
    |=> !shift_empty_reg) else $error("shift_empty not cleared by load");
  a_master_drives_clk: assert property (port_enable_reg && !is_master
    |-> !sck_oe) else $error("slave drives serial clock");
  a_phase0_bit_start: assert property (m_shift && !clock_phase_reg && m_cnt_reg == 4'h0
    |=> sck_o == clock_polarity_reg) else $error("phase 0 edge at bit start");
  a_master_sample_pt: assert property (m_sample
    |=> m_cnt_reg == spcs_pkg::PER_LAST) else $error("sample not one clock early");

endmodule : spcs_core

// ### dv/spcs_far_end.sv
`timescale 1ns/1ps
module spcs_far_end (
  // link clock and mode
  input wire logic lclk,
  input wire logic pha,
  input wire logic pol,
  input wire logic [7:0] slv_byte,
  // resolved bus lines
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic ss_n,
  // far-end drivers
  output logic p_sck,
  output logic p_mosi,
  output logic p_miso,
  output logic p_ss_n
);
  logic [7:0] got_s;
  logic [7:0] got_m;
  logic running;
  int edges;
  int idx;
  initial begin
    p_sck = 1'b0;
    p_mosi = 1'b0;
    p_ss_n = 1'b1;
    running = 1'b0;
    edges = 0;
  end
  ////////////////////////////////////////////////////////////////
  // slave role: counts both clock edges inside a select frame
  always @(negedge ss_n) edges = 0;
  always @(sck) begin
    if (ss_n === 1'b0) begin
      edges = edges + 1;
      if ((edges % 2) == (pha ? 0 : 1)) got_s = {got_s[6:0], mosi};
    end
  end
  assign idx = pha ? ((edges == 0) ? 0 : (edges - 1) / 2) : edges / 2;
  // deselected line shows the flipped last bit, so stale data never passes
  assign p_miso = (ss_n === 1'b0 && idx < 8) ? slv_byte[3'(7 - idx)] : ~slv_byte[0];
  ////////////////////////////////////////////////////////////////
  // master role: clock only moves inside a frame
  always @(pol) if (!running) p_sck = pol;
  task automatic set_ss(input logic v);
    p_ss_n = v;
  endtask : set_ss
  task automatic run_master(input logic [7:0] b);
    running = 1'b1;
    p_ss_n = 1'b0;
    repeat (3) @(posedge lclk);
    for (int i = 0; i < 8; i++) begin
      if (!pha) p_mosi = b[7 - i];
      repeat (2) @(posedge lclk);
      if (pha) p_mosi = b[7 - i];
      else got_m = {got_m[6:0], miso};
      p_sck = ~p_sck;
      repeat (2) @(posedge lclk);
      if (pha) got_m = {got_m[6:0], miso};
      p_sck = ~p_sck;
    end
    repeat (2) @(posedge lclk);
    p_ss_n = 1'b1;
    p_mosi = ~p_mosi;
    running = 1'b0;
  endtask : run_master
endmodule : spcs_far_end

// ### dv/spcs_core_tb.sv
`timescale 1ns/1ps
module spcs_core_tb;
  logic sys_clk, rstn, lclk, wr, rd, pha, pol;
  logic [7:0] addr, wdata, rdata, slv_byte;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
  logic p_sck, p_mosi, p_miso, p_ss_n;
  int errors;
  int cmp_count;
  wire sck_w = sck_oe ? sck_o : p_sck;
  wire mosi_w = mosi_oe ? mosi_o : p_mosi;
  wire miso_w = miso_oe ? miso_o : p_miso;
  wire ss_n_w = ss_n_oe ? ss_n_o : p_ss_n;
  localparam logic [7:0] CFG = spcs_pkg::CFG_ADDR;
  localparam logic [7:0] CTRL = spcs_pkg::CTRL_ADDR;
  localparam logic [7:0] DATA = spcs_pkg::DATA_ADDR;

  spcs_core i_dut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
    .slave_select_n_i(ss_n_w), .slave_select_n_o(ss_n_o), .slave_select_n_oe(ss_n_oe));
  spcs_far_end i_far (.lclk(lclk), .pha(pha), .pol(pol), .slv_byte(slv_byte), .sck(sck_w),
    .mosi(mosi_w), .miso(miso_w), .ss_n(ss_n_w), .p_sck(p_sck), .p_mosi(p_mosi),
    .p_miso(p_miso), .p_ss_n(p_ss_n));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // link clock, unrelated in phase
  initial begin
    lclk = 1'b0;
    #7;
    forever #32 lclk = ~lclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  task automatic poll_busy(input logic v, output logic [7:0] d);
    int n;
    n = 0;
    reg_rd(CFG, d);
    while (d[7] !== v && n < 200) begin
      reg_rd(CFG, d);
      n++;
    end
    if (n == 200) begin
      errors++;
      $display("unexpected busy wait expected %h seen %h", v, d[7]);
      close_out();
    end
  endtask : poll_busy
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    reg_rd(CFG, d);
    check("config at reset", 8'h07, d);
    reg_wr(CFG, 8'hFF);
    reg_rd(CFG, d);
    check("config after all ones", 8'h77, d);
    reg_wr(CFG, 8'h00);
    reg_rd(CFG, d);
    check("config after zeros", 8'h07, d);
    reg_rd(8'hA0, d);
    check("unmapped read", 8'h00, d);
  endtask : t_reset
  task automatic t_select();
    logic [7:0] d;
    i_far.set_ss(1'b0);
    repeat (8) @(posedge sys_clk);
    reg_rd(CFG, d);
    check("config while selected", 8'h0B, d);
    i_far.set_ss(1'b1);
    repeat (8) @(posedge sys_clk);
    #5;
    i_far.set_ss(1'b0);
    #20;
    i_far.set_ss(1'b1);
    reg_rd(CFG, d);
    check("selected after glitch", 8'h00, d & 8'h08);
    reg_rd(CFG, d);
    check("selected after glitch", 8'h00, d & 8'h08);
  endtask : t_select
  task automatic t_master(input logic ph, input logic po, input logic [7:0] tx,
      input logic [7:0] rx);
    logic [7:0] d;
    reg_wr(CTRL, 8'h00);
    @(posedge sys_clk);
    pha <= ph;
    pol <= po;
    slv_byte <= rx;
    reg_wr(CFG, {2'b01, ph, po, 4'h0});
    reg_wr(CTRL, 8'h09);
    #1 check("select pin out low", 8'h02, {6'h00, ss_n_oe, ss_n_o});
    reg_wr(DATA, tx);
    poll_busy(1'b1, d);
    check("empty bits in master", 8'h03, d & 8'h03);
    poll_busy(1'b0, d);
    check("clock idle level", {7'h00, po}, {7'h00, sck_w});
    check("clock edge count", 8'h10, 8'(i_far.edges));
    check("byte at slave", tx, i_far.got_s);
    reg_rd(DATA, d);
    check("byte at master", rx, d);
    reg_wr(CTRL, 8'h0D);
    #1 check("select pin out high", 8'h03, {6'h00, ss_n_oe, ss_n_o});
  endtask : t_master
  task automatic t_slave(input logic ph, input logic po, input logic [7:0] tx,
      input logic [7:0] rx);
    logic [7:0] d;
    reg_wr(CTRL, 8'h00);
    @(posedge sys_clk);
    pha <= ph;
    pol <= po;
    reg_wr(CFG, {2'b00, ph, po, 4'h0});
    reg_wr(CTRL, 8'h05);
    reg_wr(DATA, tx);
    repeat (3) @(posedge sys_clk);
    reg_rd(CFG, d);
    check("shift empty after load", 8'h00, d & 8'h02);
    i_far.run_master(rx);
    repeat (8) @(posedge sys_clk);
    reg_rd(CFG, d);
    check("status after byte", 8'h02, d & 8'h8B);
    reg_rd(DATA, d);
    check("byte at slave", rx, d);
    reg_rd(CFG, d);
    check("receive empty after read", 8'h01, d & 8'h01);
    check("byte at master", tx, i_far.got_m);
  endtask : t_slave
  ////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    cmp_count = 0;
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pha = 1'b0;
    pol = 1'b0;
    slv_byte = 8'h00;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    t_reset();
    t_select();
    for (int m = 0; m < 4; m++) t_master(m[1], m[0], 8'hA5 ^ 8'(m), 8'h3C + 8'(m));
    for (int m = 0; m < 4; m++) t_slave(m[1], m[0], 8'h96 + 8'(m), 8'h5A ^ 8'(m));
    close_out();
  end
endmodule : spcs_core_tb
